// ==== ddp_top.sv ====
// Purpose: Device-side pin command interface of a DDR2 DRAM
// Assumes: Pin clock far slower than clk_i; all pins are synchronised first
// Notes:   Burst length fixed; write lanes both timed by the lower strobe
// Operation
// - Capture control and address inputs at the rising crossing of the device clock.
// - Time read data against both clock crossings, one beat per half-cycle.
// - Clock enable high runs clocks, buffers and drivers; low stops clocks, drivers and command buffers.
// - Clock enable low: refresh gives self refresh; else idle banks give precharge down, open banks active down.
// - Power-down entry, exit and self refresh entry are clocked; self refresh exit is not.
// - Power-down keeps clock, termination, enable buffers; self refresh keeps only enable.
// - Commands sampled with rank select high are ignored.
// - Command comes from row, column and write strobes with rank select.
// - Registered termination request enables termination on data, strobe and mask pins.
// - Termination request is ignored when the extended mode register disables termination.
// - A write beat with mask sampled high is discarded.
// - Mask is sampled on both strobe edges.
// - In byte-wide mode an extended bit turns the mask pin into a read strobe.
// - Bank select picks the bank for activate, read, write and precharge.
// - During mode set, bank select picks which mode register is written.
// - Precharge closes one bank with the scope bit low, all banks when high.
// - Strobe edge-aligned with read data; centred in write data by the controller.
`timescale 1ns/1ps
`include "ddp_map.svh"
module ddp_top import ddp_pkg::*; (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ck_i,
   input  wire logic                     cke_i,
   input  wire logic                     rank_select_n_i,
   input  wire logic                     row_strobe_n_i,
   input  wire logic                     col_strobe_n_i,
   input  wire logic                     write_strobe_n_i,
   input  wire logic [`DDP_BA_W-1:0]     bank_select_i,
   input  wire logic [`DDP_ADDR_W-1:0]   addr_i,
   input  wire logic                     termination_request_i,
   input  wire logic                     lower_byte_mask_i,
   input  wire logic                     upper_byte_mask_i,
   input  wire logic                     lower_byte_strobe_i,
   input  wire logic                     upper_byte_strobe_i,
   input  wire logic [`DDP_DQ_W-1:0]     dq_i,
   input  wire logic                     wide_org_i,
   input  wire logic [4*`DDP_DQ_W-1:0]   rd_data_i,
   output logic      [`DDP_DQ_W-1:0]     dq_o,
   output logic                          dq_oe_o,
   output logic                          lower_byte_strobe_o,
   output logic                          lower_byte_strobe_oe_o,
   output logic                          upper_byte_strobe_o,
   output logic                          upper_byte_strobe_oe_o,
   output logic                          read_only_strobe_o,
   output logic                          read_only_strobe_oe_o,
   output logic      [1:0]               term_en_o,
   output logic                          clocks_on_o,
   output logic                          inbuf_cmd_en_o,
   output logic                          inbuf_ck_term_en_o,
   output logic      [3:0]               pwr_state_o,
   output logic                          cmd_valid_o,
   output logic      [2:0]               cmd_code_o,
   output logic      [`DDP_BA_W-1:0]     cmd_bank_o,
   output logic      [`DDP_ADDR_W-1:0]   cmd_addr_o,
   output logic      [`DDP_BANKS-1:0]    bank_open_o,
   output logic                          wr_valid_o,
   output logic      [`DDP_DQ_W-1:0]     wr_data_o,
   output logic      [1:0]               wr_keep_o
);
   logic [`DDP_SYNC_W-1:0] s1_q, s2_q;
   logic ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, treq_s, lmask_s, umask_s, lstb_s;
   logic [`DDP_BA_W-1:0]   ba_s;
   logic [`DDP_ADDR_W-1:0] addr_s;
   logic [`DDP_DQ_W-1:0]   dq_s;
   logic ck_prev_q, dqs_prev_q, ck_rise, ck_edge, dqs_edge;
   ddp_pwr_type pwr_q;
   ddp_cmd_type cmd_now;
   logic cmd_fire, treq_q, rtt_on, ro_stb_en;
   logic [1:0]               term_q;
   logic [`DDP_ADDR_W-1:0]   emr1;
   logic [2:0]               wr_left_q, rd_left_q;
   logic [4*`DDP_DQ_W-1:0]   rd_buf_q;
   logic                     rd_oe_q, rd_stb_q;

   // Lane keeps its data when used and its mask is low or its mask pin is a read strobe
   function automatic logic lane_keep(input logic mask, input logic used, input logic is_stb);
      lane_keep = used & (is_stb | ~mask);
   endfunction

   // Command truth table, rank select forms part of the code
   function automatic ddp_cmd_type decode(input logic cs_n, input logic ras_n,
                                          input logic cas_n, input logic we_n);
      decode = CMD_NOP;
      if (!cs_n) begin
         unique case ({ras_n, cas_n, we_n})
            3'h0: decode = CMD_MODE;
            3'h1: decode = CMD_REF;
            3'h2: decode = CMD_PRE;
            3'h3: decode = CMD_ACT;
            3'h4: decode = CMD_WR;
            3'h5: decode = CMD_RD;
            3'h6: decode = CMD_NOP;
            3'h7: decode = CMD_NOP;
         endcase
      end
   endfunction

   // Two-flop synchroniser for every pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= {ck_i, cke_i, rank_select_n_i, row_strobe_n_i, col_strobe_n_i,
                  write_strobe_n_i, bank_select_i, addr_i, termination_request_i,
                  lower_byte_mask_i, upper_byte_mask_i, lower_byte_strobe_i,
                  upper_byte_strobe_i, dq_i};
         s2_q <= s1_q;
      end
   end

   // Unpack synchronised pins; upper strobe shares the lower strobe timing
   assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s, treq_s,
           lmask_s, umask_s, lstb_s} = s2_q[`DDP_SYNC_W-1:`DDP_DQ_W+1];
   assign dq_s = s2_q[`DDP_DQ_W-1:0];

   // Edge finders on the device clock and write strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ck_prev_q  <= 1'b0;
         dqs_prev_q <= 1'b0;
      end else begin
         ck_prev_q  <= ck_s;
         dqs_prev_q <= lstb_s;
      end
   end
   assign ck_rise  = ck_s & ~ck_prev_q;
   assign ck_edge  = ck_s ^ ck_prev_q;
   assign dqs_edge = (lstb_s ^ dqs_prev_q) & (pwr_q == PW_ACTIVE);

   assign cmd_now  = decode(cs_n_s, ras_n_s, cas_n_s, we_n_s);
   assign cmd_fire = ck_rise & cke_s & (pwr_q == PW_ACTIVE) & (cmd_now != CMD_NOP);

   // Power state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwr_q <= PW_ACTIVE;
      end else begin
         unique case (pwr_q)
            PW_ACTIVE: begin
               if (ck_rise && !cke_s) begin
                  if (cmd_now == CMD_REF) begin
                     pwr_q <= PW_SELF_REF;
                  end else if (|bank_open_o) begin
                     pwr_q <= PW_ACT_PD;
                  end else begin
                     pwr_q <= PW_PRE_PD;
                  end
               end
            end
            PW_PRE_PD, PW_ACT_PD: begin
               if (ck_rise && cke_s) begin
                  pwr_q <= PW_ACTIVE;
               end
            end
            PW_SELF_REF: begin
               if (cke_s) begin
                  pwr_q <= PW_ACTIVE;
               end
            end
            default: pwr_q <= PW_ACTIVE;
         endcase
      end
   end
   assign pwr_state_o = pwr_q;

   // Clock and buffer gating
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clocks_on_o       <= 1'b0;
         inbuf_cmd_en_o    <= 1'b0;
         inbuf_ck_term_en_o <= 1'b0;
      end else begin
         clocks_on_o       <= cke_s;
         inbuf_cmd_en_o    <= (pwr_q == PW_ACTIVE);
         inbuf_ck_term_en_o <= (pwr_q != PW_SELF_REF);
      end
   end

   // Command outputs and bank tracking
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_valid_o <= 1'b0;
         cmd_code_o  <= CMD_NOP;
         cmd_bank_o  <= '0;
         cmd_addr_o  <= '0;
         bank_open_o <= '0;
      end else begin
         cmd_valid_o <= cmd_fire;
         if (cmd_fire) begin
            cmd_code_o <= cmd_now;
            cmd_bank_o <= ba_s;
            cmd_addr_o <= addr_s;
            if (cmd_now == CMD_ACT) begin
               bank_open_o[ba_s] <= 1'b1;
            end else if (cmd_now == CMD_PRE) begin
               if (addr_s[`DDP_PRE_SCOPE]) begin
                  bank_open_o <= '0;
               end else begin
                  bank_open_o[ba_s] <= 1'b0;
               end
            end
         end
      end
   end

   // Mode registers, bank select picks the target word
   ddp_mode_mem u_mode (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .wr_en_i   (cmd_fire && cmd_now == CMD_MODE),
      .wr_idx_i  (ba_s[1:0]),
      .wr_data_i (addr_s),
      .rd_idx_i  (`DDP_MR_EXT1),
      .rd_data_o (emr1)
   );
   assign rtt_on  = emr1[`DDP_EMR_RTT0] | emr1[`DDP_EMR_RTT1];
   assign ro_stb_en = emr1[`DDP_EMR_ROSTB] & ~wide_org_i;

   // Termination request, registered at the rising crossing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         treq_q <= 1'b0;
         term_q <= 2'h0;
      end else begin
         if (pwr_q == PW_SELF_REF) begin
            treq_q <= 1'b0;
         end else if (ck_rise) begin
            treq_q <= treq_s;
         end
         term_q <= {treq_q & rtt_on & wide_org_i, treq_q & rtt_on};
      end
   end
   assign term_en_o = term_q;

   // Write beats on both strobe edges, masked beats dropped per lane
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_left_q  <= 3'h0;
         wr_valid_o <= 1'b0;
         wr_data_o  <= '0;
         wr_keep_o  <= 2'h0;
      end else begin
         wr_valid_o <= 1'b0;
         if (cmd_fire && cmd_now == CMD_WR) begin
            wr_left_q <= `DDP_BEATS;
         end else if (dqs_edge && wr_left_q != 3'h0) begin
            wr_left_q  <= wr_left_q - 3'h1;
            wr_valid_o <= 1'b1;
            wr_data_o  <= dq_s;
            wr_keep_o  <= {lane_keep(umask_s, wide_org_i, 1'b0),
                           lane_keep(lmask_s, 1'b1, ro_stb_en)};
         end
      end
   end

   // Read beats on every clock crossing, strobe follows the clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_left_q <= 3'h0;
         rd_buf_q  <= '0;
         rd_oe_q   <= 1'b0;
         rd_stb_q  <= 1'b0;
         dq_o      <= '0;
      end else if (!cke_s) begin
         rd_left_q <= 3'h0;
         rd_oe_q   <= 1'b0;
      end else if (cmd_fire && cmd_now == CMD_RD) begin
         rd_left_q <= `DDP_BEATS;
         rd_buf_q  <= rd_data_i;
      end else if (ck_edge) begin
         rd_stb_q <= ck_s;
         if (rd_left_q != 3'h0) begin
            rd_left_q <= rd_left_q - 3'h1;
            dq_o      <= rd_buf_q[`DDP_DQ_W-1:0];
            rd_buf_q  <= rd_buf_q >> `DDP_DQ_W;
            rd_oe_q   <= 1'b1;
         end else begin
            rd_oe_q <= 1'b0;
         end
      end
   end
   assign dq_oe_o                = rd_oe_q;
   assign lower_byte_strobe_o    = rd_stb_q;
   assign lower_byte_strobe_oe_o = rd_oe_q;
   assign upper_byte_strobe_o    = rd_stb_q;
   assign upper_byte_strobe_oe_o = rd_oe_q & wide_org_i;
   assign read_only_strobe_o     = rd_stb_q;
   assign read_only_strobe_oe_o  = rd_oe_q & ro_stb_en;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_rd_cmd;
      cmd_fire && cmd_now == CMD_RD && cke_s;
   endsequence
   sequence s_rd_out;
      ##[1:12] (rd_oe_q && rd_stb_q == ck_s);
   endsequence

   a_cmd_masked: assert property (ck_rise && cs_n_s |=> !cmd_valid_o)
      else $error("command taken with rank select high");
   a_cmd_bank: assert property (cmd_fire |=> cmd_bank_o == $past(ba_s))
      else $error("bank select not carried with command");
   a_act_pd: assert property (pwr_q == PW_ACTIVE && ck_rise && !cke_s
                              && cmd_now != CMD_REF && |bank_open_o
                              |=> pwr_q == PW_ACT_PD)
      else $error("open row did not enter active power-down");
   a_pre_pd: assert property (pwr_q == PW_ACTIVE && ck_rise && !cke_s
                              && cmd_now != CMD_REF && bank_open_o == '0
                              |=> pwr_q == PW_PRE_PD)
      else $error("idle banks did not enter precharge power-down");
   a_sr_exit: assert property (pwr_q == PW_SELF_REF && cke_s |=> pwr_q == PW_ACTIVE)
      else $error("self refresh exit not taken without clock");
   a_pd_hold: assert property (pwr_q == PW_PRE_PD && !ck_rise |=> pwr_q == PW_PRE_PD)
      else $error("power-down left without a clock edge");
   a_term_off: assert property (!rtt_on |=> term_q == 2'h0)
      else $error("termination on while disabled");
   a_mask_drop: assert property (dqs_edge && wr_left_q != 3'h0 && lmask_s && !ro_stb_en
                                 && !(cmd_fire && cmd_now == CMD_WR)
                                 |=> wr_valid_o && !wr_keep_o[0])
      else $error("masked write beat kept");
   a_prech_all: assert property (cmd_fire && cmd_now == CMD_PRE && addr_s[`DDP_PRE_SCOPE]
                                 |=> bank_open_o == '0)
      else $error("precharge all left a bank open");
   a_rd_burst: assert property (s_rd_cmd ##1 cke_s[*4] |-> s_rd_out)
      else $error("read beat not driven on clock crossing");
   a_oe_cke: assert property (!cke_s |=> !dq_oe_o)
      else $error("drivers on while clock enable low");
endmodule

// ==== ddp_map.svh ====
// Purpose: Constants for the DRAM pin command interface
// Assumes: Included by bare name
// Notes:   Offsets here are mode register and address bit positions and burst counts
`ifndef DDP_MAP_SVH
`define DDP_MAP_SVH
`define DDP_BANKS       8
`define DDP_BA_W        3
`define DDP_ADDR_W      14
`define DDP_DQ_W        16
`define DDP_SYNC_W      44
`define DDP_BEATS       3'h4
`define DDP_PRE_SCOPE   10
`define DDP_EMR_RTT0    2
`define DDP_EMR_RTT1    6
`define DDP_EMR_ROSTB   11
`define DDP_MR_EXT1     2'h1
`define DDP_MR_RST      14'h0000
`endif

// ==== ddp_pkg.sv ====
// Purpose: Types for the DRAM pin command interface
// Assumes: Nothing
// Notes:   Power states are one-hot
package ddp_pkg;
   typedef enum logic [3:0] {
      PW_ACTIVE   = 4'h1,
      PW_PRE_PD   = 4'h2,
      PW_ACT_PD   = 4'h4,
      PW_SELF_REF = 4'h8
   } ddp_pwr_type;
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ACT = 3'h1,
      CMD_RD  = 3'h2,
      CMD_WR  = 3'h3,
      CMD_PRE = 3'h4,
      CMD_REF = 3'h5,
      CMD_MODE = 3'h6
   } ddp_cmd_type;
endpackage

// ==== ddp_mode_mem.sv ====
// Purpose: Storage of the base and extended mode registers
// Assumes: One write port, one registered read port
// Notes:   Cleared by reset
`timescale 1ns/1ps
`include "ddp_map.svh"
module ddp_mode_mem (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     wr_en_i,
   input  wire logic [1:0]               wr_idx_i,
   input  wire logic [`DDP_ADDR_W-1:0]   wr_data_i,
   input  wire logic [1:0]               rd_idx_i,
   output logic      [`DDP_ADDR_W-1:0]   rd_data_o
);
   logic [`DDP_ADDR_W-1:0] mem_q [4];

   // Write one mode register word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 4; i++) begin
            mem_q[i] <= `DDP_MR_RST;
         end
      end else if (wr_en_i) begin
         mem_q[wr_idx_i] <= wr_data_i;
      end
   end

   // Registered read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_o <= `DDP_MR_RST;
      end else begin
         rd_data_o <= mem_q[rd_idx_i];
      end
   end
endmodule

// ==== ddp_ctl_model.sv ====
// Purpose: Memory controller model driving the device pins
// Assumes: Tasks are called at clk_i falling edges
// Notes:   Pin clock stands still between commands; released lines show inverted values
`timescale 1ns/1ps
module ddp_ctl_model (
   input  wire logic        clk_i,
   output logic             ck_o,
   output logic             cke_o,
   output logic             cs_n_o,
   output logic [2:0]       cmd_n_o,
   output logic [2:0]       ba_o,
   output logic [13:0]      addr_o,
   output logic             term_req_o,
   output logic [1:0]       mask_o,
   output logic             dqs_o,
   output logic [15:0]      dq_o
);
   // Quiet pins at start: rank deselected, clock enable high
   initial begin
      {ck_o, cke_o, cs_n_o, term_req_o, dqs_o} = 5'h0c;
      {cmd_n_o, ba_o, addr_o, mask_o, dq_o} = 38'h0;
   end
   // One pin clock period of 8 clk_i cycles, rising crossing in the middle
   task automatic tick();
      repeat (4) @(negedge clk_i);
      ck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      ck_o = 1'b0;
   endtask
   // Command held across the rising crossing, then released
   task automatic cmd(input logic s, input logic [2:0] c, input logic [2:0] b,
                      input logic [13:0] a);
      @(negedge clk_i);
      {cs_n_o, cmd_n_o, ba_o, addr_o} = {s, c, b, a};
      tick();
      {cs_n_o, cmd_n_o, ba_o, addr_o} = {1'b1, ~c, ~b, ~a};
   endtask
   // Clock enable and termination request levels
   task automatic set_pins(input logic e, input logic t);
      @(negedge clk_i);
      cke_o = e;
      term_req_o = t;
   endtask
   // Four write beats, strobe edge centred in each beat
   task automatic wburst(input logic [63:0] d, input logic [7:0] m);
      cke_o = 1'b1;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_i);
         dq_o = d[16*i +: 16];
         mask_o = m[2*i +: 2];
         repeat (2) @(negedge clk_i);
         dqs_o = ~dqs_o;
         repeat (2) @(negedge clk_i);
      end
      dq_o = ~dq_o;
      mask_o = ~mask_o;
   endtask
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for the DRAM pin command interface
// Assumes: 16-bit organisation, 8-bit for the last read; stimulus at clk_i falling edges
// Notes:   Pin clock comes from the controller model at 160 ns
`timescale 1ns/1ps
`include "ddp_map.svh"
module tb import ddp_pkg::*; ;
   localparam logic [2:0] c_act = 3'h3, c_rd = 3'h5, c_wr = 3'h4, c_pre = 3'h2;
   localparam logic [2:0] c_ref = 3'h1, c_mode = 3'h0, c_nop = 3'h7;
   logic        clk_i, rst_i, ck_i, cke_i, rank_select_n_i, termination_request_i;
   logic        lower_byte_strobe_i, upper_byte_strobe_i, dq_oe_o, dqs_c, cmd_valid_o;
   logic        lower_byte_strobe_o, lower_byte_strobe_oe_o, upper_byte_strobe_o;
   logic        upper_byte_strobe_oe_o, read_only_strobe_oe_o, clocks_on_o, wr_valid_o;
   logic        inbuf_cmd_en_o, inbuf_ck_term_en_o, oe_p, st_p, wide, ro_stb;
   logic [2:0]  cmd_n, bank_select_i, cmd_code_o, cmd_bank_o;
   logic [13:0] addr_i, cmd_addr_o;
   logic [1:0]  mask, term_en_o, wr_keep_o;
   logic [15:0] dq_c, dq_i, dq_o, wr_data_o;
   logic [63:0] rd_data_i;
   logic [7:0]  bank_open_o;
   logic [3:0]  pwr_state_o;
   logic [15:0] rbeat[$], wbeat[$];
   logic [1:0]  wkeep[$];
   logic        rstrb[$];
   int          miscompares, n_compared, n_cmd;
   // Resolved two-way lines: device drives while its enable is high
   assign dq_i = dq_oe_o ? dq_o : dq_c;
   assign lower_byte_strobe_i = lower_byte_strobe_oe_o ? lower_byte_strobe_o : dqs_c;
   assign upper_byte_strobe_i = upper_byte_strobe_oe_o ? upper_byte_strobe_o : dqs_c;
   ddp_ctl_model u_ctl (.clk_i, .ck_o(ck_i), .cke_o(cke_i), .cs_n_o(rank_select_n_i),
      .cmd_n_o(cmd_n), .ba_o(bank_select_i), .addr_o(addr_i),
      .term_req_o(termination_request_i), .mask_o(mask), .dqs_o(dqs_c), .dq_o(dq_c));
   ddp_top DUT (.clk_i, .rst_i, .ck_i, .cke_i, .rank_select_n_i, .row_strobe_n_i(cmd_n[2]),
      .col_strobe_n_i(cmd_n[1]), .write_strobe_n_i(cmd_n[0]), .bank_select_i, .addr_i,
      .termination_request_i, .lower_byte_mask_i(mask[0]), .upper_byte_mask_i(mask[1]),
      .lower_byte_strobe_i, .upper_byte_strobe_i, .dq_i, .wide_org_i(wide), .rd_data_i,
      .dq_o, .dq_oe_o, .lower_byte_strobe_o, .lower_byte_strobe_oe_o, .upper_byte_strobe_o,
      .upper_byte_strobe_oe_o, .read_only_strobe_o(ro_stb), .read_only_strobe_oe_o, .term_en_o,
      .clocks_on_o, .inbuf_cmd_en_o, .inbuf_ck_term_en_o, .pwr_state_o, .cmd_valid_o,
      .cmd_code_o, .cmd_bank_o, .cmd_addr_o, .bank_open_o, .wr_valid_o, .wr_data_o,
      .wr_keep_o);
   // Clock generator
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Collect command pulses, write beats and read beats
   always @(posedge clk_i) begin
      if (cmd_valid_o)
         n_cmd++;
      if (wr_valid_o) begin
         wbeat.push_back(wr_data_o);
         wkeep.push_back(wr_keep_o);
      end
      if (dq_oe_o && (!oe_p || lower_byte_strobe_o != st_p)) begin
         rbeat.push_back(dq_o);
         rstrb.push_back(lower_byte_strobe_o);
      end
      oe_p <= dq_oe_o;
      st_p <= lower_byte_strobe_o;
   end
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One command period; e is the expected code, CMD_NOP for no pulse
   task automatic issue(input logic s, input logic [2:0] c, input logic [2:0] b,
                        input logic [13:0] a, input logic [2:0] e);
      int n0;
      n0 = n_cmd;
      u_ctl.cmd(s, c, b, a);
      chk("cmd count", e != CMD_NOP, n_cmd - n0);
      if (e != CMD_NOP) begin
         chk("cmd code", e, cmd_code_o);
         chk("cmd bank", b, cmd_bank_o);
         chk("cmd addr", a, cmd_addr_o);
      end
   endtask
   task automatic wait_pwr(input logic [3:0] e);
      int i;
      for (i = 0; i < 20 && pwr_state_o !== e; i++)
         @(negedge clk_i);
      chk("power state", e, pwr_state_o);
      if (pwr_state_o !== e)
         end_of_test();
   endtask
   // Main sequence
   initial begin
      {miscompares, n_compared, n_cmd} = 96'h0;
      rst_i = 1'b1;
      wide = 1'b1;
      rd_data_i = 64'hd4d4_c3c3_b2b2_a1a1;
      repeat (4) @(negedge clk_i);
      rst_i = 1'b0;
      chk("power after reset", PW_ACTIVE, pwr_state_o);
      chk("rows after reset", 8'h00, bank_open_o);
      repeat (3) @(negedge clk_i);
      u_ctl.set_pins(1'b1, 1'b1);
      issue(1'b0, c_nop, 3'h0, 14'h0000, CMD_NOP);
      issue(1'b1, c_act, 3'h1, 14'h0044, CMD_NOP);
      issue(1'b0, c_mode, 3'h0, 14'h0044, CMD_MODE);
      issue(1'b0, c_nop, 3'h0, 14'h0000, CMD_NOP);
      chk("termination off", 2'h0, term_en_o);
      issue(1'b0, c_mode, 3'h1, 14'h0004, CMD_MODE);
      issue(1'b0, c_nop, 3'h0, 14'h0000, CMD_NOP);
      chk("termination on", 2'h3, term_en_o);
      u_ctl.set_pins(1'b1, 1'b0);
      issue(1'b0, c_ref, 3'h0, 14'h0000, CMD_REF);
      chk("termination dropped", 2'h0, term_en_o);
      issue(1'b0, c_act, 3'h5, 14'h0123, CMD_ACT);
      chk("open rows", 8'h20, bank_open_o);
      issue(1'b0, c_wr, 3'h5, 14'h0010, CMD_WR);
      u_ctl.wburst(64'h4444_3333_2222_1111, 8'h24);
      repeat (4) @(negedge clk_i);
      chk("write beats", 4, wbeat.size());
      for (int i = 0; i < 4; i++) begin
         chk("write data", 16'h1111 * (i + 1), wbeat[i]);
         chk("write keep", 8'h24 >> (2 * i) & 2'h3 ^ 2'h3, wkeep[i]);
      end
      issue(1'b0, c_rd, 3'h5, 14'h0020, CMD_RD);
      chk("mask pin as strobe", 1'b0, read_only_strobe_oe_o);
      u_ctl.cmd(1'b1, c_nop, 3'h0, 14'h0000);
      chk("upper strobe drive", 1'b1, upper_byte_strobe_oe_o);
      u_ctl.cmd(1'b1, c_nop, 3'h0, 14'h0000);
      chk("read beats", 4, rbeat.size());
      for (int i = 0; i < 4; i++) begin
         chk("read data", rd_data_i[16*i +: 16], rbeat[i]);
         chk("read strobe", i % 2, rstrb[i]);
      end
      repeat (4) @(negedge clk_i);
      chk("read drive off", 1'b0, dq_oe_o);
      issue(1'b0, c_act, 3'h2, 14'h0001, CMD_ACT);
      issue(1'b0, c_pre, 3'h5, 14'h0000, CMD_PRE);
      chk("open rows", 8'h04, bank_open_o);
      u_ctl.set_pins(1'b0, 1'b0);
      issue(1'b0, c_nop, 3'h0, 14'h0000, CMD_NOP);
      wait_pwr(PW_ACT_PD);
      repeat (2) @(negedge clk_i);
      chk("clocks", 1'b0, clocks_on_o);
      chk("cmd buffers", 1'b0, inbuf_cmd_en_o);
      chk("clock buffers", 1'b1, inbuf_ck_term_en_o);
      issue(1'b0, c_act, 3'h6, 14'h0002, CMD_NOP);
      u_ctl.set_pins(1'b1, 1'b0);
      issue(1'b0, c_nop, 3'h0, 14'h0000, CMD_NOP);
      wait_pwr(PW_ACTIVE);
      issue(1'b0, c_pre, 3'h0, 14'h0400, CMD_PRE);
      chk("open rows", 8'h00, bank_open_o);
      u_ctl.set_pins(1'b0, 1'b0);
      issue(1'b0, c_nop, 3'h0, 14'h0000, CMD_NOP);
      wait_pwr(PW_PRE_PD);
      u_ctl.set_pins(1'b1, 1'b0);
      issue(1'b0, c_nop, 3'h0, 14'h0000, CMD_NOP);
      wait_pwr(PW_ACTIVE);
      u_ctl.set_pins(1'b0, 1'b0);
      issue(1'b0, c_ref, 3'h0, 14'h0000, CMD_NOP);
      wait_pwr(PW_SELF_REF);
      repeat (2) @(negedge clk_i);
      chk("clock buffers", 1'b0, inbuf_ck_term_en_o);
      u_ctl.set_pins(1'b1, 1'b0);
      wait_pwr(PW_ACTIVE);
      repeat (2) @(negedge clk_i);
      chk("clocks", 1'b1, clocks_on_o);
      chk("cmd buffers", 1'b1, inbuf_cmd_en_o);
      // Byte-wide organisation: mask pin becomes a read strobe
      wide = 1'b0;
      issue(1'b0, c_mode, 3'h1, 14'h0804, CMD_MODE);
      issue(1'b0, c_rd, 3'h3, 14'h0000, CMD_RD);
      u_ctl.cmd(1'b1, c_nop, 3'h0, 14'h0000);
      chk("mask pin as strobe", 1'b1, read_only_strobe_oe_o);
      chk("read only strobe", 1'b1, ro_stb);
      chk("upper strobe drive", 1'b0, upper_byte_strobe_oe_o);
      end_of_test();
   end
endmodule
